/* File: rtl/sensor_serial_register_port.sv */
// Sensor end of the two-wire serial register port with its register array.
// What this block does
// - Eight bits MSB first, then one acknowledge.
// - START anywhere restarts, slave address expected next.
// - Data changes only while clock is low.
// - Answer only address 1110x10, x from pin.
// - Eighth address bit: one reads, zero writes.
// - Acknowledge matching address after next falling clock.
// - Write carries two register address bytes, data.
// - Further write bytes go to incremented addresses.
// - STOP ends transfer, port goes idle.
// - Read sends register at held address.
// - Held address survives repeated START for reads.
// - Release data line during read acknowledge bit.
// - Master acknowledge requests next higher register.
// - Master no-acknowledge releases line, returns idle.
// - Held address persists between transfers.
// - Address advances at acknowledge bit rising edge.
// - Bytes continue until STOP, START or a master no-acknowledge on a read.
// - Works with serial clock up to 400 kbit/s.
`timescale 1ns/1ns
`default_nettype none
module sensor_serial_register_port
  import serial_port_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic bus_address_select_pin,
  serial_link_if.device link,
  output logic reg_wr_valid,
  output logic [REG_ADDR_W-1:0] reg_wr_addr,
  output logic [DATA_W-1:0] reg_wr_data,
  output logic port_busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG_HI, ST_REG_LO, ST_WDATA, ST_RDATA} port_state_e;

  // ****************************************
  // Pin synchronisers, link clock domain
  // ****************************************
  // Bit 0 is the serial clock, bit 1 the data line, bit 2 the select pin.
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] pin_flt_ff;
  logic [2:0] nxt_pin_flt;
  logic [1:0] pin_prev_ff;
  logic ce_s1_ff;
  logic ce_s2_ff;

  assign pin_raw = {bus_address_select_pin, link.serial_bus_data_line, link.scl_level};

  always_comb begin
    // A level counts only once the second and third stages agree.
    nxt_pin_flt = (pin_s2_ff & pin_s3_ff) | (pin_flt_ff & (pin_s2_ff | pin_s3_ff));
  end

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      pin_s1_ff <= 3'h7;
      pin_s2_ff <= 3'h7;
      ce_s1_ff <= 1'b0;
      ce_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      ce_s1_ff <= clk_en;
      ce_s2_ff <= ce_s1_ff;
    end
  end

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      pin_s3_ff <= 3'h7;
      pin_flt_ff <= 3'h7;
      pin_prev_ff <= 2'h3;
    end else if (ce_s2_ff) begin
      pin_s3_ff <= pin_s2_ff;
      pin_flt_ff <= nxt_pin_flt;
      pin_prev_ff <= pin_flt_ff[1:0];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_now;
  // Conditions are decoded from the filtered lines, never the raw pins.
  assign sda_now = pin_flt_ff[1];
  assign scl_rise = pin_flt_ff[0] & ~pin_prev_ff[0];
  assign scl_fall = ~pin_flt_ff[0] & pin_prev_ff[0];
  assign start_det = pin_flt_ff[0] & pin_prev_ff[0] & pin_prev_ff[1] & ~sda_now;
  assign stop_det = pin_flt_ff[0] & pin_prev_ff[0] & ~pin_prev_ff[1] & sda_now;

  // ****************************************
  // Transfer engine and register array
  // ****************************************
  port_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [DATA_W-1:0] shift_ff, nxt_shift;
  logic [REG_ADDR_W-1:0] addr_ff, nxt_addr;
  logic rd_mode_ff, nxt_rd_mode;
  logic nack_ff, nxt_nack;
  logic sda_oe_ff, nxt_sda_oe;
  logic wr_tgl_ff, nxt_wr_tgl;
  logic busy_lk_ff;
  logic [REG_ADDR_W-1:0] wr_addr_l_ff, nxt_wr_addr_l;
  logic [DATA_W-1:0] wr_data_l_ff, nxt_wr_data_l;
  logic mem_we;
  logic [DATA_W-1:0] mem_ff [2**MEM_AW];
  logic [DATA_W-1:0] mem_rd;
  logic [6:0] own_addr;

  assign mem_rd = mem_ff[addr_ff[MEM_AW-1:0]];
  assign own_addr = {SLAVE_ADDR_HI, pin_flt_ff[2], SLAVE_ADDR_LO};

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_rd_mode = rd_mode_ff;
    nxt_nack = nack_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_wr_tgl = wr_tgl_ff;
    nxt_wr_addr_l = wr_addr_l_ff;
    nxt_wr_data_l = wr_data_l_ff;
    mem_we = 1'b0;
    if (start_det) begin
      // The held address is left alone so a restart can read from it.
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (state_ff != ST_IDLE && scl_rise) begin
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
      if (bit_cnt_ff < ACK_SLOT && state_ff != ST_RDATA) begin
        nxt_shift = {shift_ff[DATA_W-2:0], sda_now};
      end
      if (bit_cnt_ff == ACK_SLOT && state_ff == ST_WDATA) begin
        nxt_addr = addr_ff + 16'h0001;
      end
      if (bit_cnt_ff == ACK_SLOT && state_ff == ST_RDATA) begin
        nxt_addr = addr_ff + 16'h0001;
        nxt_nack = sda_now;
      end
    end else if (state_ff != ST_IDLE && scl_fall) begin
      if (bit_cnt_ff == ACK_SLOT) begin
        unique case (state_ff)
          ST_ADDR: begin
            if (shift_ff[7:1] == own_addr) begin
              nxt_sda_oe = 1'b1;
              nxt_rd_mode = shift_ff[0];
            end else begin
              nxt_state = ST_IDLE;
            end
          end
          ST_REG_HI: begin
            nxt_addr = {shift_ff, addr_ff[7:0]};
            nxt_sda_oe = 1'b1;
          end
          ST_REG_LO: begin
            nxt_addr = {addr_ff[15:8], shift_ff};
            nxt_sda_oe = 1'b1;
          end
          ST_WDATA: begin
            mem_we = 1'b1;
            nxt_wr_tgl = ~wr_tgl_ff;
            nxt_wr_addr_l = addr_ff;
            nxt_wr_data_l = shift_ff;
            nxt_sda_oe = 1'b1;
          end
          ST_RDATA: begin
            nxt_sda_oe = 1'b0;
          end
          default: begin
            nxt_state = ST_IDLE;
          end
        endcase
      end else if (bit_cnt_ff == SLOT_END) begin
        nxt_bit_cnt = 4'h0;
        nxt_sda_oe = 1'b0;
        unique case (state_ff)
          ST_ADDR: nxt_state = rd_mode_ff ? ST_RDATA : ST_REG_HI;
          ST_REG_HI: nxt_state = ST_REG_LO;
          ST_REG_LO: nxt_state = ST_WDATA;
          ST_WDATA: nxt_state = ST_WDATA;
          ST_RDATA: nxt_state = nack_ff ? ST_IDLE : ST_RDATA;
          default: nxt_state = ST_IDLE;
        endcase
        if ((state_ff == ST_ADDR && rd_mode_ff) || (state_ff == ST_RDATA && !nack_ff)) begin
          // The address held now is sent, whether set by a write or kept.
          nxt_shift = mem_rd;
          nxt_sda_oe = ~mem_rd[DATA_W-1];
        end
      end else if (state_ff == ST_RDATA) begin
        nxt_shift = {shift_ff[DATA_W-2:0], 1'b0};
        nxt_sda_oe = ~shift_ff[DATA_W-2];
      end
    end
  end

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      addr_ff <= REG_ADDR_RST;
      rd_mode_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      wr_tgl_ff <= 1'b0;
      busy_lk_ff <= 1'b0;
      wr_addr_l_ff <= REG_ADDR_RST;
      wr_data_l_ff <= 8'h00;
    end else if (ce_s2_ff) begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      rd_mode_ff <= nxt_rd_mode;
      nack_ff <= nxt_nack;
      sda_oe_ff <= nxt_sda_oe;
      wr_tgl_ff <= nxt_wr_tgl;
      busy_lk_ff <= (nxt_state != ST_IDLE);
      wr_addr_l_ff <= nxt_wr_addr_l;
      wr_data_l_ff <= nxt_wr_data_l;
    end
  end

  always_ff @(posedge clk_link) begin
    if (ce_s2_ff && mem_we) begin
      mem_ff[addr_ff[MEM_AW-1:0]] <= shift_ff;
    end
  end

  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = sda_oe_ff;

  // ****************************************
  // Report writes into the system clock domain
  // ****************************************
  // Latched address and data stay still for a whole byte time, far longer
  // than the toggle takes to cross, so they are sampled without a second sync.
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic busy_s1_ff;
  logic busy_s2_ff;
  logic wr_valid_ff, nxt_wr_valid;
  logic [REG_ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [DATA_W-1:0] wr_data_ff, nxt_wr_data;
  logic busy_ff;

  always_comb begin
    nxt_wr_valid = tgl_s2_ff ^ tgl_s3_ff;
    nxt_wr_addr = nxt_wr_valid ? wr_addr_l_ff : wr_addr_ff;
    nxt_wr_data = nxt_wr_valid ? wr_data_l_ff : wr_data_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= wr_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      busy_s1_ff <= busy_lk_ff;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgl_s3_ff <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= REG_ADDR_RST;
      wr_data_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else if (clk_en) begin
      tgl_s3_ff <= tgl_s2_ff;
      wr_valid_ff <= nxt_wr_valid;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      busy_ff <= busy_s2_ff;
    end
  end

  assign reg_wr_valid = wr_valid_ff;
  assign reg_wr_addr = wr_addr_ff;
  assign reg_wr_data = wr_data_ff;
  assign port_busy = busy_ff;
endmodule
`default_nettype wire

/* File: rtl/serial_port_pkg.sv */
// Shared constants and types for the two-wire serial register port.
package serial_port_pkg;
  // ****************************************
  // Widths and protocol fields
  // ****************************************
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 16;
  localparam logic [3:0] SLAVE_ADDR_HI = 4'he;
  localparam logic [1:0] SLAVE_ADDR_LO = 2'h2;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] SLOT_END = 4'h9;
  localparam logic [REG_ADDR_W-1:0] REG_ADDR_RST = 16'h0000;
  // ****************************************
  // Serial clock timing
  // ****************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int QUARTER_NS = 625;
  localparam int QUARTER_CYC = (QUARTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int QCNT_W = 8;
  // ****************************************
  // Host byte-level operations
  // ****************************************
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} bus_op_e;
endpackage

/* File: rtl/serial_link_if.sv */
// Open-drain two-wire link joining the bus master and the sensor port.
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl_level;
  logic serial_bus_data_line;
  // A line is low when any enabled driver pulls it low; pull-ups do the rest.
  assign scl_level = !(scl_oe && !scl_out);
  assign serial_bus_data_line = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
  modport device (
    input scl_level,
    input serial_bus_data_line,
    output sda_dev_out,
    output sda_dev_oe
  );
  modport host (
    input scl_level,
    input serial_bus_data_line,
    output scl_out,
    output scl_oe,
    output sda_host_out,
    output sda_host_oe
  );
endinterface
`default_nettype wire

/* File: rtl/serial_bus_master.sv */
// Bus master end of the two-wire serial register port.
`timescale 1ns/1ns
`default_nettype none
module serial_bus_master
  import serial_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bus_op_e cmd_op,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic cmd_nack,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_ack_seen,
  serial_link_if.host link
);
  typedef enum logic {HS_IDLE, HS_RUN} host_state_e;
  localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QUARTER_CYC - 1);

  // ****************************************
  // Data line synchroniser
  // ****************************************
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;
  logic sda_flt_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
      sda_flt_ff <= 1'b1;
    end else begin
      sda_s1_ff <= link.serial_bus_data_line;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      sda_flt_ff <= (sda_s2_ff == sda_s3_ff) ? sda_s3_ff : sda_flt_ff;
    end
  end

  // ****************************************
  // Quarter-bit sequencer
  // ****************************************
  // Each operation is four quarters per bit; the clock is made by dividing
  // the system clock, so no second domain exists on this end.
  host_state_e state_ff, nxt_state;
  bus_op_e op_ff, nxt_op;
  logic [QCNT_W-1:0] qcnt_ff, nxt_qcnt;
  logic [1:0] step_ff, nxt_step;
  logic [3:0] bit_ff, nxt_bit;
  logic [DATA_W-1:0] sh_ff, nxt_sh;
  logic nack_ff, nxt_nack;
  logic scl_oe_ff, nxt_scl_oe;
  logic sda_oe_ff, nxt_sda_oe;
  logic ready_ff, nxt_ready;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic ack_seen_ff, nxt_ack_seen;
  logic tick;
  logic is_data;

  assign tick = (qcnt_ff == QTR_LAST);
  assign is_data = (op_ff == OP_WRITE) || (op_ff == OP_READ);

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_qcnt = qcnt_ff;
    nxt_step = step_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_nack = nack_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ready = ready_ff;
    nxt_rsp_valid = 1'b0;
    nxt_ack_seen = ack_seen_ff;
    if (state_ff == HS_IDLE) begin
      if (cmd_valid && ready_ff) begin
        nxt_state = HS_RUN;
        nxt_op = cmd_op;
        nxt_sh = cmd_data;
        nxt_nack = cmd_nack;
        nxt_qcnt = '0;
        nxt_step = 2'h0;
        nxt_bit = 4'h0;
        nxt_ready = 1'b0;
      end
    end else if (!tick) begin
      nxt_qcnt = qcnt_ff + 1'b1;
    end else begin
      nxt_qcnt = '0;
      nxt_step = step_ff + 2'h1;
      unique case (step_ff)
        2'h0: begin
          if (op_ff == OP_START) begin
            nxt_sda_oe = 1'b0;
          end else if (op_ff == OP_STOP) begin
            nxt_sda_oe = 1'b1;
          end else if (bit_ff < ACK_SLOT) begin
            nxt_sda_oe = (op_ff == OP_WRITE) && !sh_ff[DATA_W-1];
          end else begin
            nxt_sda_oe = (op_ff == OP_READ) && !nack_ff;
          end
        end
        2'h1: nxt_scl_oe = 1'b0;
        2'h2: begin
          if (op_ff == OP_START) begin
            nxt_sda_oe = 1'b1;
          end else if (op_ff == OP_STOP) begin
            nxt_sda_oe = 1'b0;
          end else if (bit_ff < ACK_SLOT) begin
            nxt_sh = {sh_ff[DATA_W-2:0], sda_flt_ff};
          end else begin
            nxt_ack_seen = !sda_flt_ff;
          end
        end
        default: begin
          if (op_ff != OP_STOP) begin
            nxt_scl_oe = 1'b1;
          end
          if (is_data && bit_ff != ACK_SLOT) begin
            nxt_bit = bit_ff + 4'h1;
          end else begin
            nxt_state = HS_IDLE;
            nxt_ready = 1'b1;
            nxt_rsp_valid = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= HS_IDLE;
      op_ff <= OP_START;
      qcnt_ff <= '0;
      step_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      nack_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      qcnt_ff <= nxt_qcnt;
      step_ff <= nxt_step;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      nack_ff <= nxt_nack;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      ready_ff <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      ack_seen_ff <= nxt_ack_seen;
    end
  end

  assign link.scl_out = 1'b0;
  assign link.scl_oe = scl_oe_ff;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = sda_oe_ff;
  assign cmd_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = sh_ff;
  assign rsp_ack_seen = ack_seen_ff;
endmodule
`default_nettype wire

/* File: tb/serial_port_monitor.sv */
// Wire-level checker for the two-wire serial register link.
`timescale 1ns/1ns
`default_nettype none
module serial_port_monitor (
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic resetn,
  input wire logic scl_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl_level,
  input wire logic serial_bus_data_line
);
  // ********
  // Helper counters on the link clock
  // ********
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  logic [3:0] falls_ff;
  logic [3:0] nxt_falls;
  logic start_seen;
  logic scl_fall;
  always_comb begin
    start_seen = scl_level && scl_q_ff && sda_q_ff && !serial_bus_data_line;
    scl_fall = scl_q_ff && !scl_level;
    nxt_age = scl_fall ? 4'h0 : (age_ff == 4'hf ? 4'hf : age_ff + 4'h1);
    nxt_falls = falls_ff;
    if (start_seen) begin
      nxt_falls = 4'h0;
    end else if (scl_fall && falls_ff != 4'hf) begin
      nxt_falls = falls_ff + 4'h1;
    end
  end
  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      age_ff <= 4'hf;
      falls_ff <= 4'h0;
    end else begin
      scl_q_ff <= scl_level;
      sda_q_ff <= serial_bus_data_line;
      age_ff <= nxt_age;
      falls_ff <= nxt_falls;
    end
  end
  // ********
  // Properties
  // ********
  property p_ack_after_addr;
    @(posedge clk_link) disable iff (!resetn) $rose(sda_dev_oe) |-> falls_ff >= 4'h9;
  endproperty
  a_ack_after_addr: assert property (p_ack_after_addr) else $error("device drove early");
  property p_answer_lat;
    @(posedge clk_link) disable iff (!resetn) $changed(sda_dev_oe) |-> age_ff <= 4'ha;
  endproperty
  a_answer_lat: assert property (p_answer_lat) else $error("device answer late");
  property p_dev_still_high;
    @(posedge clk_link) disable iff (!resetn)
      scl_level && $past(scl_level) |-> $stable(sda_dev_oe);
  endproperty
  a_dev_still_high: assert property (p_dev_still_high) else $error("device moved data");
  property p_no_contend;
    @(posedge clk_link) disable iff (!resetn) scl_level |-> !(sda_dev_oe && sda_host_oe);
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("both pull data line");
  property p_stop_release;
    @(posedge clk_link) disable iff (!resetn)
      scl_level && $rose(serial_bus_data_line) |-> !sda_dev_oe;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("device held at stop");
  property p_stop_idle;
    @(posedge clk_link) disable iff (!resetn)
      scl_level && $rose(serial_bus_data_line) |=> scl_level [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("clock moved after stop");
  property p_scl_low_min;
    @(posedge clk_sys) disable iff (!resetn) $rose(scl_oe) |-> ##125 scl_oe;
  endproperty
  a_scl_low_min: assert property (p_scl_low_min) else $error("clock low too short");
  property p_scl_high_min;
    @(posedge clk_sys) disable iff (!resetn) $fell(scl_oe) |-> ##125 !scl_oe;
  endproperty
  a_scl_high_min: assert property (p_scl_high_min) else $error("clock high too short");
  c_ack: cover property (@(posedge clk_link) $rose(sda_dev_oe));
  c_restart: cover property (@(posedge clk_link) start_seen && falls_ff >= 4'h9);
  c_host_ack: cover property (@(posedge clk_link) scl_level && sda_host_oe && !sda_dev_oe);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench joining the bus master and the sensor port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb;
  import serial_port_pkg::*;
  logic clk_sys, clk_link, resetn, cmd_valid, cmd_nack, pin;
  bus_op_e cmd_op;
  logic [DATA_W-1:0] cmd_data, rsp_data, rd_cap, reg_wr_data;
  logic cmd_ready, rsp_valid, rsp_ack_seen, ack_cap, reg_wr_valid, port_busy;
  logic [REG_ADDR_W-1:0] reg_wr_addr;
  logic [23:0] wq[$];
  int err_total, checked;
  serial_link_if i_serial_link_if ();
  sensor_serial_register_port i_sensor_serial_register_port (.clk_sys(clk_sys),
    .clk_link(clk_link), .resetn(resetn), .clk_en(1'b1), .bus_address_select_pin(pin),
    .link(i_serial_link_if), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .port_busy(port_busy));
  serial_bus_master i_serial_bus_master (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack_seen(rsp_ack_seen), .link(i_serial_link_if));
  serial_port_monitor i_serial_port_monitor (.clk_sys(clk_sys), .clk_link(clk_link),
    .resetn(resetn), .scl_oe(i_serial_link_if.scl_oe),
    .sda_host_oe(i_serial_link_if.sda_host_oe), .sda_dev_oe(i_serial_link_if.sda_dev_oe),
    .scl_level(i_serial_link_if.scl_level),
    .serial_bus_data_line(i_serial_link_if.serial_bus_data_line));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // The link clock has a 6 ns period against 10 ns, so its edges drift against the system clock.
  initial begin
    clk_link = 1'b0;
    #1;
    forever #3 clk_link = ~clk_link;
  end
  always @(posedge clk_sys) begin
    if (reg_wr_valid === 1'b1) begin
      wq.push_back({reg_wr_addr, reg_wr_data});
    end
  end
  // ********
  // Command tasks
  // ********
  task automatic op(input bus_op_e o, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_nack <= nk;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 3000) err_total++;
    rd_cap = rsp_data;
    ack_cap = rsp_ack_seen;
  endtask
  task automatic wr(input logic [7:0] d, input logic ea);
    op(OP_WRITE, d, 1'b0);
    `CHK("ack", ea, ack_cap)
  endtask
  task automatic rdb(input logic nk, input logic [7:0] ex);
    op(OP_READ, 8'h00, nk);
    `CHK("rdata", ex, rd_cap)
  endtask
  task automatic wchk(input logic [15:0] a, input logic [7:0] d);
    logic [23:0] g;
    g = {24{1'bx}};
    if (wq.size() != 0) g = wq.pop_front();
    `CHK("write", {a, d}, g)
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #900000;
    err_total++;
    close_out;
  end
  // ********
  // Scenarios
  // ********
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    pin = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (20) @(posedge clk_sys);
    op(OP_START, 8'h00, 1'b0);
    wr(8'he4, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'ha5, 1'b1);
    wr(8'h3c, 1'b1);
    wr(8'h7e, 1'b1);
    `CHK("busy", 1'b1, port_busy)
    op(OP_STOP, 8'h00, 1'b0);
    `CHK("busy", 1'b0, port_busy)
    `CHK("ready", 1'b1, cmd_ready)
    wchk(16'h0010, 8'ha5);
    wchk(16'h0011, 8'h3c);
    wchk(16'h0012, 8'h7e);
    // Address-only write, then a restart into a read.
    op(OP_START, 8'h00, 1'b0);
    wr(8'he4, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h10, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    wr(8'he5, 1'b1);
    rdb(1'b0, 8'ha5);
    rdb(1'b1, 8'h3c);
    op(OP_STOP, 8'h00, 1'b0);
    // The last byte was refused yet still moved the address on.
    op(OP_START, 8'h00, 1'b0);
    wr(8'he5, 1'b1);
    rdb(1'b1, 8'h7e);
    op(OP_STOP, 8'h00, 1'b0);
    `CHK("wcount", 32'h0, wq.size())
    for (int p = 1; p >= 0; p--) begin
      @(posedge clk_sys);
      pin <= p[0];
      repeat (20) @(posedge clk_sys);
      for (int k = 0; k < 2; k++) begin
        op(OP_START, 8'h00, 1'b0);
        wr({4'he, k[0], 3'h4}, k[0] == p[0]);
        op(OP_STOP, 8'h00, 1'b0);
      end
    end
    // A restart after one register address byte, which the next write replaces.
    op(OP_START, 8'h00, 1'b0);
    wr(8'he4, 1'b1);
    wr(8'h00, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    wr(8'he4, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h20, 1'b1);
    wr(8'h99, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    wchk(16'h0020, 8'h99);
    `CHK("wcount", 32'h0, wq.size())
    close_out;
  end
endmodule
`default_nettype wire
